// [bench/tb_vectored_interrupt_prioritizer.sv]
/*
  Self-checking bench of the prioritizer with a core model.
  Assumes the design defaults: all sources present.
*/
`timescale 1ns/100ps
`include "vip_defs.svh"
module tb_vectored_interrupt_prioritizer
  import vip_pkg::*;
;
  // ****************************************
  // Signals
  // ****************************************
  logic clk, rst_n, gset, gclr, ack, irq, gie, cen;
  logic [7:0] pa, sel, rev, cnt;
  logic [3:0] pc;
  logic [2:0] dly;
  logic [15:0] vec, cvec;
  logic [`VIP_N_SLOT-1:0] sclr, sset, pend, exp_m, z;
  vip_periph_t per;
  vip_trap_t trp;
  vip_lvl_t [`VIP_N_SLOT-1:0] lvl;
  logic [15:0] exp_q[$];
  int error_cnt, checked;

  vip_prioritizer i_dut (.i_clk(clk), .i_rst_n(rst_n), .i_pa_pin(pa),
    .i_pa_rise_sel(sel), .i_pc_pin(pc), .i_periph(per), .i_trap(trp),
    .i_prio_level(lvl), .i_sw_clr(sclr), .i_sw_set(sset),
    .i_irq_enable_set(gset), .i_irq_enable_clr(gclr), .i_ack(ack),
    .o_irq_req(irq), .o_vector(vec), .o_pending(pend),
    .o_global_irq_enable(gie));
  vip_core_model i_core (.i_clk(clk), .i_rst_n(rst_n), .i_en(cen),
    .i_delay(dly), .i_irq_req(irq), .i_vector(vec), .o_ack(ack),
    .o_vec(cvec), .o_cnt(cnt));

  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic [15:0] slot_vec(input int s);
    if (s == 4)
      return `VIP_VEC_ADC;
    if (s < 4)
      return `VIP_VEC_T1 + `VIP_VEC_STEP * 16'(s);
    if (s < 13)
      return `VIP_VEC_PA7 + `VIP_VEC_STEP * 16'(s - 5);
    return `VIP_VEC_PC3 + `VIP_VEC_STEP * 16'(s - 13);
  endfunction : slot_vec

  task automatic chk(input logic ok, input string msg);
    checked++;
    if (!ok)
    begin
      error_cnt++;
      $display("Error %0t %s", $time, msg);
    end
  endtask : chk

  task automatic test_done();
    if (error_cnt == 0 && checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : test_done

  task automatic build(input logic [`VIP_N_SLOT-1:0] m);
    for (int l = 3; l > 0; l--)
      for (int s = 0; s < `VIP_N_SLOT; s++)
        if (m[s] && lvl[s] == 2'(l))
          exp_q.push_back(slot_vec(s));
  endtask : build

  task automatic pulse(input logic [`VIP_N_SLOT-1:0] m, input logic c);
    if (c)
      sclr <= m;
    else
      sset <= m;
    @(posedge clk);
    sclr <= '0;
    sset <= '0;
    @(posedge clk);
    #1;
  endtask : pulse

  task automatic drain();
    logic [7:0] n;
    while (exp_q.size() > 0)
    begin
      n = cnt;
      cen <= 1'b1;
      gset <= 1'b1;
      dly <= 3'($urandom_range(0, 4));
      @(posedge clk);
      gset <= 1'b0;
      for (int t = 0; t < 50 && cnt == n; t++)
        @(posedge clk);
      #1;
      chk(cvec === exp_q.pop_front(), "vector order");
      chk(gie === 1'b0 && irq === 1'b0, "state after ack");
    end
    cen <= 1'b0;
  endtask : drain

  // ****************************************
  // Tests
  // ****************************************
  initial
  begin
    rst_n = 1'b0;
    {pa, sel, pc, dly, gset, gclr, cen} = '0;
    {per, trp, lvl, sclr, sset} = '0;
    error_cnt = 0;
    checked = 0;
    void'($urandom(70649));
    repeat (3) @(posedge clk);
    #1;
    chk(irq === 1'b0 && vec === `VIP_VEC_RESET && pend === '0
      && gie === 1'b0, "reset values");
    rst_n <= 1'b1;
    exp_q.push_back(`VIP_VEC_RESET);
    drain();
    lvl <= {`VIP_N_SLOT{2'h2}};
    pulse('1, 1'b0);
    build('1);
    drain();
    chk(pend === '0, "all served");
    repeat (25)
    begin
      exp_m = `VIP_N_SLOT'($urandom);
      for (int s = 0; s < `VIP_N_SLOT; s++)
        lvl[s] <= 2'($urandom_range(0, 3));
      pulse(exp_m, 1'b0);
      for (int s = 0; s < `VIP_N_SLOT; s++)
        z[s] = exp_m[s] && lvl[s] == 2'h0;
      build(exp_m);
      drain();
      chk(pend === z && irq === 1'b0, "disabled flags kept");
      pulse('1, 1'b1);
      chk(pend === '0, "software clear");
    end
    for (int s = 0; s < `VIP_N_SLOT; s++)
      lvl[s] <= 2'($urandom_range(1, 3));
    gset <= 1'b1;
    @(posedge clk);
    gset <= 1'b0;
    per <= '1;
    trp <= '1;
    @(posedge clk);
    per <= '0;
    trp <= '0;
    @(posedge clk);
    #1;
    chk(pend === `VIP_N_SLOT'(7'h7F), "event flags");
    exp_q = {`VIP_VEC_WDT, `VIP_VEC_POSC, `VIP_VEC_WOSC, `VIP_VEC_ILL};
    build(`VIP_N_SLOT'(7'h7F));
    drain();
    sel <= 8'($urandom);
    gset <= 1'b1;
    gclr <= 1'b1;
    @(posedge clk);
    {gset, gclr} <= 2'h0;
    pa <= 8'hFF;
    pc <= 4'hF;
    repeat (6) @(posedge clk);
    #1;
    rev = {<<{sel}};
    chk(gie === 1'b0 && irq === 1'b0, "polled only");
    chk(pend === {4'hF, rev, 5'h00}, "rising edges");
    pa <= 8'h00;
    pc <= 4'h0;
    pulse('1, 1'b1);
    repeat (6) @(posedge clk);
    #1;
    chk(pend === {4'hF, ~rev, 5'h00}, "falling edges");
    build(pend);
    drain();
    test_done();
  end

  initial
  begin
    repeat (60000) @(posedge clk);
    error_cnt++;
    test_done();
  end
endmodule : tb_vectored_interrupt_prioritizer

// [bench/vip_core_model.sv]
/*
  Core model: acknowledges a presented request after a chosen delay.
  Assumes the prioritizer's clock and synchronous active-low reset.
*/
`timescale 1ns/100ps
module vip_core_model
(
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // Control
  input wire logic i_en,
  input wire logic [2:0] i_delay,
  // Prioritizer side
  input wire logic i_irq_req,
  input wire logic [15:0] i_vector,
  output logic o_ack,
  output logic [15:0] o_vec,
  output logic [7:0] o_cnt
);
  logic [2:0] wait_r;

  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      o_ack <= 1'b0;
      wait_r <= 3'h0;
      o_cnt <= 8'h00;
      o_vec <= 16'h0000;
    end
    else if (o_ack || !i_irq_req || !i_en)
    begin
      o_ack <= 1'b0;
      wait_r <= 3'h0;
    end
    else if (wait_r == i_delay)
    begin
      o_ack <= 1'b1;
      o_vec <= {i_vector[15:8], i_vector[7:0]};
      o_cnt <= o_cnt + 8'h01;
    end
    else
      wait_r <= wait_r + 3'h1;
  end
endmodule : vip_core_model

// [core/vip_edge_detect.sv]
/*
  One pin edge detector: two-flop synchroniser, then a one-cycle pulse
  on the chosen edge, or on both. Assumes an asynchronous pin input.
*/
`timescale 1ns/100ps
module vip_edge_detect
  import vip_pkg::*;
#(
  parameter bit BOTH_EDGES = 1'b0
)
(
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // Pin and edge choice
  input wire logic i_pin,
  input wire logic i_rise_sel,
  // Event
  output logic o_pulse
);
  logic sync1_r;
  logic sync2_r;
  logic prev_r;
  logic pulse_r;
  logic pulse_nxt;

  // ***********************************************
  // Edge choice
  // ***********************************************
  always_comb
  begin
    pulse_nxt = 1'b0;
    if (sync2_r != prev_r)
    begin
      if (BOTH_EDGES)
        pulse_nxt = 1'b1; // R4
      else
        pulse_nxt = (sync2_r == i_rise_sel); // R3
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      sync1_r <= 1'b0;
      sync2_r <= 1'b0;
      prev_r <= 1'b0;
      pulse_r <= 1'b0;
    end
    else
    begin
      sync1_r <= i_pin;
      sync2_r <= sync1_r;
      prev_r <= sync2_r;
      pulse_r <= pulse_nxt;
    end
  end

  assign o_pulse = pulse_r;

  AST_ONE_PULSE: assert property (@(posedge i_clk) disable iff (!i_rst_n) // R15
    pulse_r |=> !pulse_r)
    else $error("edge pulse longer than one cycle");
endmodule : vip_edge_detect

// [core/vip_prioritizer.sv]
/*
  Vectored interrupt prioritizer: pending flags, three-level ranking,
  trap and reset entries, vector presentation to the core.
  Assumes same-clock one-cycle pulses from peripherals, traps and core.
*/
`timescale 1ns/100ps
`include "vip_defs.svh"
module vip_prioritizer
  import vip_pkg::*;
#(
  parameter bit HAS_ADC = 1'b1,
  parameter logic [`VIP_N_PA-1:0] PA_PRESENT = 8'hFF,
  parameter logic [`VIP_N_PC-1:0] PC_PRESENT = 4'hF
)
(
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // Port pins and edge choice
  input wire logic [`VIP_N_PA-1:0] i_pa_pin,
  input wire logic [`VIP_N_PA-1:0] i_pa_rise_sel,
  input wire logic [`VIP_N_PC-1:0] i_pc_pin,
  // Peripheral and trap pulses
  input wire vip_periph_t i_periph,
  input wire vip_trap_t i_trap,
  // Software control
  input wire vip_lvl_t [`VIP_N_SLOT-1:0] i_prio_level,
  input wire logic [`VIP_N_SLOT-1:0] i_sw_clr,
  input wire logic [`VIP_N_SLOT-1:0] i_sw_set,
  input wire logic i_irq_enable_set,
  input wire logic i_irq_enable_clr,
  // Core
  input wire logic i_ack,
  output logic o_irq_req,
  output logic [15:0] o_vector,
  output logic [`VIP_N_SLOT-1:0] o_pending,
  output logic o_global_irq_enable
);
  // ***********************************************
  // Pin events
  // ***********************************************
  logic [`VIP_N_PA-1:0] pa_ev;
  logic [`VIP_N_PC-1:0] pc_ev;

  for (genvar p = 0; p < `VIP_N_PA; p++)
  begin : g_pa
    vip_edge_detect #(.BOTH_EDGES(1'b0)) u_pa (
      .i_clk(i_clk),
      .i_rst_n(i_rst_n),
      .i_pin(i_pa_pin[p]),
      .i_rise_sel(i_pa_rise_sel[p]),
      .o_pulse(pa_ev[p])
    );
  end

  for (genvar q = 0; q < `VIP_N_PC; q++)
  begin : g_pc
    vip_edge_detect #(.BOTH_EDGES(1'b1)) u_pc (
      .i_clk(i_clk),
      .i_rst_n(i_rst_n),
      .i_pin(i_pc_pin[q]),
      .i_rise_sel(1'b0),
      .o_pulse(pc_ev[q])
    );
  end

  // ***********************************************
  // Slot events in table order
  // ***********************************************
  logic [`VIP_N_SLOT-1:0] ev_s;

  always_comb
  begin
    ev_s = '0;
    ev_s[0] = i_periph.timer1; // R12
    ev_s[1] = i_periph.timer0;
    ev_s[2] = i_periph.uart_rx;
    ev_s[3] = i_periph.uart_tx;
    ev_s[4] = i_periph.adc & HAS_ADC; // R14
    for (int p = 0; p < `VIP_N_PA; p++)
      ev_s[`VIP_SLOT_PA_TOP-p] = pa_ev[p] & PA_PRESENT[p]; // R13 R14
    for (int q = 0; q < `VIP_N_PC; q++)
      ev_s[`VIP_SLOT_PC_TOP-q] = pc_ev[q] & PC_PRESENT[q]; // R4 R14
    ev_s[5] = ev_s[5] | i_periph.low_voltage_detector; // R6 R7
    ev_s[6] = ev_s[6] | i_periph.comparator; // R7
  end

  // ***********************************************
  // Entry helpers
  // ***********************************************
  function automatic logic [15:0] vec_of(input int e);
    case (e)
      0: vec_of = `VIP_VEC_RESET; // R10
      1: vec_of = `VIP_VEC_WDT; // R6
      2: vec_of = `VIP_VEC_POSC; // R11
      3: vec_of = `VIP_VEC_WOSC;
      4: vec_of = `VIP_VEC_ILL;
      5: vec_of = `VIP_VEC_T1; // R12
      6: vec_of = `VIP_VEC_T0;
      7: vec_of = `VIP_VEC_URX;
      8: vec_of = `VIP_VEC_UTX;
      9: vec_of = `VIP_VEC_ADC;
      10: vec_of = `VIP_VEC_PA7; // R7
      11: vec_of = `VIP_VEC_PA6;
      12, 13, 14, 15, 16, 17: // R13
        vec_of = `VIP_VEC_PA5 + `VIP_VEC_STEP * 16'(e - 12);
      18, 19, 20, 21: // R4
        vec_of = `VIP_VEC_PC3 + `VIP_VEC_STEP * 16'(e - 18);
      default: vec_of = `VIP_VEC_RESET;
    endcase
  endfunction : vec_of

  function automatic vip_lvl_t lvl_of(input int e,
                                      input vip_lvl_t [`VIP_N_SLOT-1:0] pl);
    if (e < `VIP_SLOT_BASE)
      lvl_of = `VIP_LVL_TOP;
    else
      lvl_of = pl[e-`VIP_SLOT_BASE]; // R5
  endfunction : lvl_of

  // ***********************************************
  // Flags and ranking
  // ***********************************************
  logic [`VIP_N_SLOT-1:0] pend_r;
  logic [`VIP_N_SLOT-1:0] pend_nxt;
  logic [`VIP_E_ILL:0] trap_r;
  logic [`VIP_E_ILL:0] trap_nxt;
  logic gie_r;
  logic gie_nxt;
  logic req_r;
  logic req_nxt;
  vip_entry_t sel_r;
  vip_entry_t sel_nxt;
  logic [15:0] vec_r;
  logic [15:0] vec_nxt;
  logic [`VIP_N_ENTRY-1:0] flag_all;
  logic [`VIP_N_ENTRY-1:0] elig;
  logic [`VIP_N_ENTRY-1:0] ack_clr;
  vip_lvl_t best_lvl;
  vip_entry_t best;
  logic any_elig;
  logic taken;

  always_comb
  begin
    flag_all = {pend_r, trap_r};
    for (int e = 0; e < `VIP_N_ENTRY; e++)
      elig[e] = flag_all[e] && lvl_of(e, i_prio_level) != `VIP_LVL_OFF &&
                (gie_r || (e != 1 && e < `VIP_SLOT_BASE)); // R8
    best_lvl = `VIP_LVL_OFF;
    best = '0;
    any_elig = |elig;
    for (int e = `VIP_N_ENTRY - 1; e >= 0; e--)
      if (elig[e] && lvl_of(e, i_prio_level) >= best_lvl)
      begin
        best_lvl = lvl_of(e, i_prio_level); // R16
        best = vip_entry_t'(e);
      end
  end

  always_comb
  begin
    taken = req_r && i_ack;
    ack_clr = '0;
    if (taken)
      ack_clr[sel_r] = 1'b1; // R17
    // Set wins over any clear in the same cycle
    pend_nxt = (pend_r & ~ack_clr[`VIP_N_ENTRY-1:`VIP_SLOT_BASE] & ~i_sw_clr)
               | ev_s | i_sw_set; // R15 R17
    trap_nxt = (trap_r & ~ack_clr[`VIP_E_ILL:0]) |
               {i_trap.illegal_instr, i_trap.wdt_osc_fail,
                i_trap.osc_fail, i_periph.watchdog, 1'b0}; // R6 R11
    gie_nxt = gie_r;
    if (taken || i_irq_enable_clr)
      gie_nxt = 1'b0; // R18
    else if (i_irq_enable_set)
      gie_nxt = 1'b1;
    if (req_r && !taken && elig[sel_r])
    begin
      req_nxt = 1'b1; // R19
      sel_nxt = sel_r;
      vec_nxt = vec_r;
    end
    else
    begin
      req_nxt = any_elig && !taken;
      sel_nxt = best;
      vec_nxt = vec_of(int'(best)); // R1 R2 R20
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      pend_r <= '0;
      trap_r <= 5'h01; // R10
      gie_r <= 1'b0;
      req_r <= 1'b0;
      sel_r <= '0;
      vec_r <= `VIP_VEC_RESET;
    end
    else
    begin
      pend_r <= pend_nxt;
      trap_r <= trap_nxt;
      gie_r <= gie_nxt;
      req_r <= req_nxt;
      sel_r <= sel_nxt;
      vec_r <= vec_nxt;
    end
  end

  // Vector word is driven whole; byte order in memory is the core's
  assign o_irq_req = req_r; // R9
  assign o_vector = vec_r;
  assign o_pending = pend_r;
  assign o_global_irq_enable = gie_r;

  // ***********************************************
  // Checks
  // ***********************************************
  logic higher_exists;

  always_comb
  begin
    higher_exists = 1'b0;
    for (int e = 0; e < `VIP_N_ENTRY; e++)
      if (elig[e] && lvl_of(e, i_prio_level) > lvl_of(int'(best),
                                                       i_prio_level))
        higher_exists = 1'b1;
  end

  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_rst_n);

  AST_ACK_DISABLES: assert property ( // R18
    req_r && i_ack |=> !gie_r && !req_r)
    else $error("acknowledge left interrupts enabled");

  AST_RESET_WINS: assert property ( // R10
    trap_r[0] && !req_r |=> req_r && vec_r == `VIP_VEC_RESET)
    else $error("reset entry not presented first");

  AST_NO_RESERVED: assert property ( // R20
    req_r |-> !(vec_r inside {`VIP_VEC_RSV0, `VIP_VEC_RSV1, `VIP_VEC_RSV2,
      `VIP_VEC_RSV3, `VIP_VEC_RSV4, `VIP_VEC_RSV5, `VIP_VEC_RSV6,
      `VIP_VEC_RSV7}))
    else $error("reserved vector presented");

  AST_POLL_QUIET: assert property ( // R8
    req_r && (sel_r == `VIP_E_WDT || sel_r >= `VIP_SLOT_BASE)
    |-> $past(gie_r))
    else $error("interrupt presented while globally disabled");

  AST_PULSE_LATCHED: assert property ( // R15
    |ev_s |=> (pend_r & $past(ev_s)) == $past(ev_s))
    else $error("event pulse not latched");

  AST_SW_CLEAR: assert property ( // R17
    |(i_sw_clr & ~ev_s & ~i_sw_set)
    |=> (pend_r & $past(i_sw_clr & ~ev_s & ~i_sw_set)) == '0)
    else $error("software clear ignored");

  AST_LEVEL_ORDER: assert property ( // R16
    any_elig |-> !higher_exists)
    else $error("lower level chosen over higher");

  AST_ADC_ABSENT: assert property ( // R14
    !HAS_ADC && !i_sw_set[4] |=> !pend_r[4] || $past(pend_r[4]))
    else $error("absent converter raised a request");

  AST_HOLD: assert property ( // R19
    req_r && !i_ack && elig[sel_r] |=> req_r && $stable(vec_r))
    else $error("presented vector changed before acknowledge");
endmodule : vip_prioritizer

// [include/vip_defs.svh]
/*
  Constants of the vectored interrupt prioritizer: entry indices, vectors,
  source counts and levels. Assumes it is included by its bare name.
*/
// What this block does
// (R1) Twenty sources mapped onto eighteen vectors
// (R2) Twelve pin sources, eight peripheral sources
// (R3) Port A pins: one selectable edge each
// (R4) Port C pins 3..0: both edges, lowest
// (R5) Per-source level beats fixed table order
// (R6) Watchdog and low-voltage detector raise interrupts
// (R7) Pin 7 shares detector, pin 6 comparator
// (R8) Polling: no request to core, flags readable
// (R9) Vector word: high byte even address
// (R10) Reset highest, fixed vector, not interrupt
// (R11) After watchdog: oscillator, watchdog-oscillator, illegal traps
// (R12) Peripheral order timer1, timer0, rx, tx, converter
// (R13) Port A pins rank seven down to zero
// (R14) Absent hardware sources never raise requests
// (R15) Sources pulse one cycle; pulses latched pending
// (R16) Level three beats two beats one
// (R17) Flag clears on acknowledge or software zero
// (R18) Acknowledge clears global interrupt enable
// (R19) Winner and vector held until acknowledged; the code drops the hold once the winner is no longer eligible
// (R20) Reserved vector slots never presented
`ifndef VIP_DEFS_SVH
`define VIP_DEFS_SVH

`define VIP_N_SLOT 17
`define VIP_N_ENTRY 22
`define VIP_N_PA 8
`define VIP_N_PC 4
`define VIP_SLOT_BASE 5
`define VIP_SLOT_PA_TOP 12
`define VIP_SLOT_PC_TOP 16

`define VIP_E_RESET 5'h00
`define VIP_E_WDT 5'h01
`define VIP_E_POSC 5'h02
`define VIP_E_WOSC 5'h03
`define VIP_E_ILL 5'h04

`define VIP_LVL_OFF 2'h0
`define VIP_LVL_TOP 2'h3

`define VIP_VEC_RESET 16'h0002
`define VIP_VEC_WDT 16'h0004
`define VIP_VEC_POSC 16'h003A
`define VIP_VEC_WOSC 16'h003C
`define VIP_VEC_ILL 16'h0006
`define VIP_VEC_T1 16'h000A
`define VIP_VEC_T0 16'h000C
`define VIP_VEC_URX 16'h000E
`define VIP_VEC_UTX 16'h0010
`define VIP_VEC_ADC 16'h0016
`define VIP_VEC_PA7 16'h0018
`define VIP_VEC_PA6 16'h001A
`define VIP_VEC_PA5 16'h001C
`define VIP_VEC_STEP 16'h0002
`define VIP_VEC_PC3 16'h0030

`define VIP_VEC_RSV0 16'h0008
`define VIP_VEC_RSV1 16'h0012
`define VIP_VEC_RSV2 16'h0014
`define VIP_VEC_RSV3 16'h0028
`define VIP_VEC_RSV4 16'h002A
`define VIP_VEC_RSV5 16'h002C
`define VIP_VEC_RSV6 16'h002E
`define VIP_VEC_RSV7 16'h0038

`endif

// [include/vip_pkg.sv]
/*
  Types of the vectored interrupt prioritizer.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package vip_pkg;
  typedef logic [1:0] vip_lvl_t;
  typedef logic [4:0] vip_entry_t;

  typedef struct packed {
    logic timer1;
    logic timer0;
    logic uart_rx;
    logic uart_tx;
    logic adc;
    logic low_voltage_detector;
    logic comparator;
    logic watchdog;
  } vip_periph_t;

  typedef struct packed {
    logic osc_fail;
    logic wdt_osc_fail;
    logic illegal_instr;
  } vip_trap_t;
endpackage : vip_pkg
